// ===== core/system_clock_mode_control.sv
// System clock source selection, oscillator ready flags and stop/wake power-mode control
module system_clock_mode_control #(
  parameter int CRYSTAL_CYCLES = clk_mode_pkg::CRYSTAL_READY_CYCLES,
  parameter int FAST_RC_CYCLES = clk_mode_pkg::FAST_RC_READY_CYCLES,
  parameter int SLOW_RC_CYCLES = clk_mode_pkg::SLOW_RC_READY_CYCLES
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic halt_in,
  input wire logic wake_in,
  input wire logic sysclk_keep_in_idle_in,
  input wire logic sub_clk_needed_in,
  input wire logic [1:0] high_osc_kind_in,
  input wire logic high_osc_tick_in,
  input wire logic low_osc_tick_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  output logic high_osc_en_out,
  output logic low_osc_en_out,
  output logic sys_clk_tick_out,
  output logic cpu_run_out,
  output logic [5:0] high_div_ticks_out
);
  initial begin
    if (CRYSTAL_CYCLES < 2 || CRYSTAL_CYCLES > 4095 || FAST_RC_CYCLES < 2 ||
        FAST_RC_CYCLES > 4095 || SLOW_RC_CYCLES < 1 || SLOW_RC_CYCLES > 15) begin
      $error("Oscillator settle counts out of range");
    end
  end

  clk_mode_pkg::clock_mode_reg_t ctrl_q;
  clk_mode_pkg::power_state_t state_q;
  clk_mode_pkg::power_state_t stop_kind_q;
  logic high_ready_q;
  logic low_ready_q;
  logic [11:0] high_cnt_q;
  logic [3:0] low_cnt_q;
  logic substitute_q;
  logic [5:0] div_cnt_q;
  logic [2:0] act_src_q;
  logic pending_q;
  logic [2:0] req_src;
  logic [2:0] eff_src;
  logic [6:0] src_ticks;
  logic high_on;
  logic low_on;
  logic sys_clk_running;
  logic crystal_sel;
  logic quick_ok;
  logic [11:0] high_target;
  logic apb_hit;
  logic apb_done;

  // Source requested by the register: 0 undivided, 1..6 fH/2..fH/64, 7 slow RC
  always_comb begin
    if (ctrl_q.high_low_clk_sel) begin
      req_src = clk_mode_pkg::SRC_UNDIVIDED;
    end else if (ctrl_q.div_sel[2:1] == 2'h0) begin
      req_src = clk_mode_pkg::SRC_SLOW;
    end else begin
      req_src = 3'h7 - ctrl_q.div_sel + 3'h1;
    end
  end

  // Substitute slow clock overrides the request while the crystal settles
  assign eff_src = substitute_q ? clk_mode_pkg::SRC_SLOW : req_src;
  assign crystal_sel = high_osc_kind_in == 2'(clk_mode_pkg::OSC_CRYSTAL);
  assign quick_ok = crystal_sel && ctrl_q.quick_wake_en &&
                    (stop_kind_q == clk_mode_pkg::ST_LIGHT_STOP ||
                     stop_kind_q == clk_mode_pkg::ST_IDLE_STOPPED);
  assign high_target = crystal_sel ? 12'(CRYSTAL_CYCLES) : 12'(FAST_RC_CYCLES);

  // High-speed oscillator runs only when some consumer is on a high source
  always_comb begin
    high_on = 1'b0;
    if (state_q == clk_mode_pkg::ST_RUN || state_q == clk_mode_pkg::ST_WAKING ||
        state_q == clk_mode_pkg::ST_IDLE_RUNNING) begin
      high_on = (req_src != clk_mode_pkg::SRC_SLOW);
    end
  end
  assign low_on = state_q != clk_mode_pkg::ST_DEEP_STOP;

  // Tick candidates per source; divided ticks come from one synchronous 6-bit counter
  assign src_ticks[0] = high_osc_tick_in && high_on;
  assign src_ticks[7 - 1] = high_osc_tick_in && high_on && (div_cnt_q == 6'h3F);
  genvar gi;
  generate
    for (gi = 1; gi < clk_mode_pkg::DIV_STAGES; gi++) begin : g_div
      assign src_ticks[gi] = high_osc_tick_in && high_on && (&div_cnt_q[gi - 1:0]);
    end
  endgenerate

  assign sys_clk_running = (state_q == clk_mode_pkg::ST_RUN) ||
                           (state_q == clk_mode_pkg::ST_IDLE_RUNNING);

  // Divider counter on fH ticks
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_cnt_q <= 6'h00;
    end else if (clk_en_in) begin
      if (!high_on) begin
        div_cnt_q <= 6'h00;
      end else if (high_osc_tick_in) begin
        div_cnt_q <= div_cnt_q + 6'h01;
      end
    end
  end

  // Glitch-free switch: the old source ends its cycle, then the new one takes over
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_src_q <= clk_mode_pkg::SRC_UNDIVIDED;
      pending_q <= 1'b0;
    end else if (clk_en_in) begin
      pending_q <= eff_src != act_src_q;
      if (eff_src != act_src_q) begin
        if (act_src_q == clk_mode_pkg::SRC_SLOW) begin
          if (low_osc_tick_in || !low_on) begin
            act_src_q <= eff_src;
          end
        end else if (src_ticks[act_src_q] || !high_on) begin
          act_src_q <= eff_src;
        end
      end
    end
  end

  // System and peripheral tick outputs
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sys_clk_tick_out <= 1'b0;
      high_div_ticks_out <= 6'h00;
    end else if (clk_en_in) begin
      high_div_ticks_out <= src_ticks[6:1];
      if (!sys_clk_running || pending_q || eff_src != act_src_q) begin
        sys_clk_tick_out <= 1'b0;
      end else if (act_src_q == clk_mode_pkg::SRC_SLOW) begin
        sys_clk_tick_out <= low_osc_tick_in && low_ready_q;
      end else begin
        sys_clk_tick_out <= src_ticks[act_src_q];
      end
    end
  end

  // High-speed ready: cleared while the oscillator is off, set after the settle count
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      high_cnt_q <= 12'h000;
      high_ready_q <= 1'b0;
    end else if (clk_en_in) begin
      if (!high_on) begin
        high_cnt_q <= 12'h000;
        high_ready_q <= 1'b0;
      end else if (high_osc_tick_in && !high_ready_q) begin
        if (high_cnt_q == high_target - 12'h001) begin
          high_ready_q <= 1'b1;
        end
        high_cnt_q <= high_cnt_q + 12'h001;
      end
    end
  end

  // Low-speed ready: cleared in deep stop, set after the slow RC settle count
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_cnt_q <= 4'h0;
      low_ready_q <= 1'b0;
    end else if (clk_en_in) begin
      if (!low_on) begin
        low_cnt_q <= 4'h0;
        low_ready_q <= 1'b0;
      end else if (low_osc_tick_in && !low_ready_q) begin
        if (low_cnt_q == 4'(SLOW_RC_CYCLES - 1)) begin
          low_ready_q <= 1'b1;
        end
        low_cnt_q <= low_cnt_q + 4'h1;
      end
    end
  end

  // Power-mode sequencer: stop entry and wake-up completion
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= clk_mode_pkg::ST_RUN;
      stop_kind_q <= clk_mode_pkg::ST_RUN;
      substitute_q <= 1'b0;
    end else if (clk_en_in) begin
      case (state_q)
        clk_mode_pkg::ST_RUN: begin
          if (substitute_q && high_ready_q) begin
            substitute_q <= 1'b0;
          end
          if (halt_in && !substitute_q) begin
            if (ctrl_q.idle_on_stop && sysclk_keep_in_idle_in) begin
              state_q <= clk_mode_pkg::ST_IDLE_RUNNING;
            end else if (ctrl_q.idle_on_stop) begin
              state_q <= clk_mode_pkg::ST_IDLE_STOPPED;
            end else if (sub_clk_needed_in) begin
              state_q <= clk_mode_pkg::ST_LIGHT_STOP;
            end else begin
              state_q <= clk_mode_pkg::ST_DEEP_STOP;
            end
          end
        end
        clk_mode_pkg::ST_IDLE_RUNNING: begin
          if (wake_in) begin
            state_q <= clk_mode_pkg::ST_RUN;
          end
        end
        clk_mode_pkg::ST_IDLE_STOPPED, clk_mode_pkg::ST_LIGHT_STOP,
        clk_mode_pkg::ST_DEEP_STOP: begin
          if (wake_in) begin
            stop_kind_q <= state_q;
            state_q <= clk_mode_pkg::ST_WAKING;
          end
        end
        clk_mode_pkg::ST_WAKING: begin
          if (req_src == clk_mode_pkg::SRC_SLOW) begin
            if (low_ready_q) begin
              state_q <= clk_mode_pkg::ST_RUN;
            end
          end else if (quick_ok && low_ready_q) begin
            substitute_q <= !high_ready_q;
            state_q <= clk_mode_pkg::ST_RUN;
          end else if (high_ready_q) begin
            state_q <= clk_mode_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= clk_mode_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Oscillator enables and CPU run level
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      high_osc_en_out <= 1'b0;
      low_osc_en_out <= 1'b0;
      cpu_run_out <= 1'b0;
    end else if (clk_en_in) begin
      high_osc_en_out <= high_on;
      low_osc_en_out <= low_on;
      cpu_run_out <= state_q == clk_mode_pkg::ST_RUN;
    end
  end

  // APB slave: one register, answered on the second access-phase edge
  assign apb_hit = paddr_in == clk_mode_pkg::CLOCK_MODE_REG_ADDR;
  assign apb_done = psel_in && penable_in && !pready_out;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else if (clk_en_in) begin
      pready_out <= apb_done;
      pslverr_out <= apb_done && !apb_hit;
      if (apb_done && !pwrite_in && apb_hit) begin
        prdata_out <= {24'h000000, ctrl_q.div_sel, ctrl_q.quick_wake_en, low_ready_q,
                       high_ready_q, ctrl_q.idle_on_stop, ctrl_q.high_low_clk_sel};
      end else begin
        prdata_out <= 32'h00000000;
      end
    end
  end

  // Writable control fields; ready flags are read-only live state
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q.div_sel <= clk_mode_pkg::DIV_SEL_RESET;
      ctrl_q.quick_wake_en <= clk_mode_pkg::QUICK_WAKE_RESET;
      ctrl_q.low_osc_ready <= 1'b0;
      ctrl_q.high_osc_ready <= 1'b0;
      ctrl_q.idle_on_stop <= clk_mode_pkg::IDLE_ON_STOP_RESET;
      ctrl_q.high_low_clk_sel <= clk_mode_pkg::HIGH_LOW_SEL_RESET;
    end else if (clk_en_in) begin
      ctrl_q.low_osc_ready <= low_ready_q;
      ctrl_q.high_osc_ready <= high_ready_q;
      if (apb_done && pwrite_in && apb_hit) begin
        ctrl_q.div_sel <= pwdata_in[clk_mode_pkg::DIV_SEL_LSB +: 3];
        ctrl_q.quick_wake_en <= pwdata_in[clk_mode_pkg::QUICK_WAKE_BIT];
        ctrl_q.idle_on_stop <= pwdata_in[clk_mode_pkg::IDLE_ON_STOP_BIT];
        ctrl_q.high_low_clk_sel <= pwdata_in[clk_mode_pkg::HIGH_LOW_SEL_BIT];
      end
    end
  end
endmodule

// ===== core/clk_mode_pkg.sv
// Package: register layout, reset values, timing counts and types of the clock mode block
package clk_mode_pkg;
  localparam logic [11:0] CLOCK_MODE_REG_ADDR = 12'h000;
  localparam int DIV_SEL_LSB = 5;
  localparam int QUICK_WAKE_BIT = 4;
  localparam int LOW_READY_BIT = 3;
  localparam int HIGH_READY_BIT = 2;
  localparam int IDLE_ON_STOP_BIT = 1;
  localparam int HIGH_LOW_SEL_BIT = 0;
  localparam logic [2:0] DIV_SEL_RESET = 3'h0;
  localparam logic QUICK_WAKE_RESET = 1'b0;
  localparam logic IDLE_ON_STOP_RESET = 1'b1;
  localparam logic HIGH_LOW_SEL_RESET = 1'b1;
  localparam int CRYSTAL_READY_CYCLES = 1024;
  localparam int FAST_RC_READY_CYCLES = 16;
  localparam int SLOW_RC_READY_CYCLES = 2;
  localparam int DIV_STAGES = 6;
  localparam logic [2:0] SRC_UNDIVIDED = 3'h0;
  localparam logic [2:0] SRC_SLOW = 3'h7;

  typedef enum logic [1:0] {
    OSC_CRYSTAL,
    OSC_EXTERNAL_RC,
    OSC_INTERNAL_FAST_RC,
    OSC_RESERVED
  } high_osc_kind_t;

  typedef enum {
    ST_RUN,
    ST_IDLE_RUNNING,
    ST_IDLE_STOPPED,
    ST_LIGHT_STOP,
    ST_DEEP_STOP,
    ST_WAKING
  } power_state_t;

  typedef struct packed {
    logic [2:0] div_sel;
    logic quick_wake_en;
    logic low_osc_ready;
    logic high_osc_ready;
    logic idle_on_stop;
    logic high_low_clk_sel;
  } clock_mode_reg_t;
endpackage

// ===== dv/system_clock_mode_control_sva.sv
// Checker: bus and clock-mode properties at the block's ports
module system_clock_mode_control_sva (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic halt_in,
  input wire logic high_osc_tick_in,
  input wire logic low_osc_tick_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire logic high_osc_en_out,
  input wire logic low_osc_en_out,
  input wire logic sys_clk_tick_out,
  input wire logic cpu_run_out,
  input wire logic [5:0] high_div_ticks_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Bus answers after one wait, for one cycle, with no data on a refusal
  chk_bus_answer: assert property (psel_in && penable_in && clk_en_in && !pready_out
    |=> pready_out) else $error("bus answer missing");
  chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("ready held");
  chk_err_data: assert property (pready_out && pslverr_out |-> prdata_out == 32'h0)
    else $error("data on refused access");
  // Clock outputs only follow a source tick
  chk_div_off: assert property (!high_osc_en_out [*3] |-> high_div_ticks_out == 6'h00)
    else $error("divided ticks while oscillator off");
  chk_div_cause: assert property (|high_div_ticks_out |-> $past(high_osc_tick_in))
    else $error("divided tick without source tick");
  chk_sys_cause: assert property (sys_clk_tick_out |-> $past(high_osc_tick_in) ||
    $past(low_osc_tick_in)) else $error("system tick without source tick");
  // Power modes, plus covers for halt, refused access and high oscillator off
  chk_halt_entry: assert property (cpu_run_out && halt_in && clk_en_in |-> ##2
    !cpu_run_out) else $error("halt did not stop cpu");
  chk_slow_alive: assert property (cpu_run_out |-> low_osc_en_out)
    else $error("slow oscillator off while running");
  cov_halt: cover property (cpu_run_out && halt_in);
  cov_refused: cover property (pready_out && pslverr_out);
  cov_high_off: cover property (!high_osc_en_out && cpu_run_out);
endmodule

bind system_clock_mode_control system_clock_mode_control_sva chk (.mclk_in, .resetn_in,
  .clk_en_in, .psel_in, .penable_in, .halt_in, .high_osc_tick_in, .low_osc_tick_in,
  .pready_out, .pslverr_out, .prdata_out, .high_osc_en_out, .low_osc_en_out,
  .sys_clk_tick_out, .cpu_run_out, .high_div_ticks_out);

// ===== dv/osc_model.sv
// Oscillator model: high-speed and slow RC tick sources gated by their enables
module osc_model #(
  parameter int HIGH_DIV = 2,
  parameter int LOW_DIV = 8
) (
  input wire logic mclk_in,
  input wire logic high_en_in,
  input wire logic low_en_in,
  output logic high_tick_out,
  output logic low_tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int hcnt;
  int lcnt;
  initial begin
    high_tick_out = 1'b0;
    low_tick_out = 1'b0;
  end
  // A stopped oscillator gives no ticks and restarts from its first phase
  always @(posedge mclk_in) begin
    hcnt <= high_en_in ? (hcnt + 1) % HIGH_DIV : 0;
    lcnt <= low_en_in ? (lcnt + 1) % LOW_DIV : 0;
    high_tick_out <= high_en_in && hcnt == HIGH_DIV - 1;
    low_tick_out <= low_en_in && lcnt == LOW_DIV - 1;
  end
endmodule

// ===== dv/system_clock_mode_control_tb.sv
// Testbench: register access, clock selection and stop/wake sequences
module system_clock_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, resetn_in = 0, clk_en_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic halt_in = 0, wake_in = 0, sysclk_keep_in_idle_in = 1, sub_clk_needed_in = 0;
  logic high_osc_tick_in, low_osc_tick_in, pready_out, pslverr_out, e;
  logic high_osc_en_out, low_osc_en_out, sys_clk_tick_out, cpu_run_out;
  logic [1:0] high_osc_kind_in = 2'h0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, v;
  logic [5:0] high_div_ticks_out;
  int fail_count, n_tests;
  system_clock_mode_control #(.CRYSTAL_CYCLES(64), .FAST_RC_CYCLES(4)) dut (.mclk_in,
    .resetn_in, .clk_en_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .halt_in, .wake_in, .sysclk_keep_in_idle_in, .sub_clk_needed_in, .high_osc_kind_in,
    .high_osc_tick_in, .low_osc_tick_in, .pready_out, .pslverr_out, .prdata_out,
    .high_osc_en_out, .low_osc_en_out, .sys_clk_tick_out, .cpu_run_out, .high_div_ticks_out);
  osc_model #(.HIGH_DIV(2), .LOW_DIV(8)) osc (.mclk_in, .high_en_in(high_osc_en_out),
    .low_en_in(low_osc_en_out), .high_tick_out(high_osc_tick_in), .low_tick_out(low_osc_tick_in));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // One bus transfer, held until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    check("apb_ready", pready_out, 1);
    v = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task pulse(input bit w);
    if (w) wake_in <= 1'b1;
    else halt_in <= 1'b1;
    @(posedge mclk_in);
    wake_in <= 1'b0;
    halt_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  // Cycles between two system ticks, after two ticks have been let pass
  task gap(input int exp, input string nm);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge mclk_in);
        n++;
      end while (sys_clk_tick_out !== 1'b1 && n < 3000);
    end
    check(nm, n, exp);
  endtask
  // Cycles between two ticks of one peripheral divider tap
  task div_gap(input int k, input int exp, input string nm);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge mclk_in);
        n++;
      end while (high_div_ticks_out[k] !== 1'b1 && n < 3000);
    end
    check(nm, n, exp);
  endtask
  task poll(input int b, input string nm);
    int n;
    n = 0;
    do begin
      apb(0, 12'h000, 32'h0);
      n++;
    end while (v[b] !== 1'b1 && n < 100);
    check(nm, v[b], 1);
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    apb(0, 12'h000, 32'h0);
    check("reset_value", v, 32'h03);
    repeat (300) @(posedge mclk_in);
    apb(0, 12'h000, 32'h0);
    check("ready_flags", v, 32'h0F);
    apb(0, 12'h004, 32'h0);
    check("unmapped_err", e, 1);
    check("unmapped_data", v, 32'h0);
    gap(2, "undivided_gap");
    for (int c = 0; c < 8; c++) begin
      apb(1, 12'h000, {24'h0, c[2:0], 5'h02});
      apb(0, 12'h000, 32'h0);
      check("div_reg", v & 32'hF3, {24'h0, c[2:0], 5'h02});
      gap(c < 2 ? 8 : 2 << (8 - c), "div_gap");
      if (c < 2) check("high_osc_off", high_osc_en_out, 0);
      if (c < 2) check("div_ticks_off", high_div_ticks_out, 0);
      if (c < 2) poll(3, "slow_ready");
    end
    apb(1, 12'h000, 32'h03);
    poll(2, "high_ready_back");
    gap(2, "fast_gap");
    div_gap(0, 4, "div2_tap");
    div_gap(5, 128, "div64_tap");
    pulse(0);
    repeat (2) @(posedge mclk_in);
    check("idle_cpu_off", cpu_run_out, 0);
    gap(2, "idle_gap");
    pulse(1);
    repeat (3) @(posedge mclk_in);
    check("idle_wake", cpu_run_out, 1);
    sysclk_keep_in_idle_in <= 1'b0;
    apb(1, 12'h000, 32'h11);
    pulse(0);
    repeat (4) @(posedge mclk_in);
    check("deep_low_off", low_osc_en_out, 0);
    apb(0, 12'h000, 32'h0);
    check("deep_flags", v, 32'h11);
    // A wake while the clock enable is low must be lost
    clk_en_in <= 1'b0;
    pulse(1);
    repeat (4) @(posedge mclk_in);
    check("frozen_wake", low_osc_en_out, 0);
    clk_en_in <= 1'b1;
    pulse(1);
    gap(2, "deep_wake_gap");
    sub_clk_needed_in <= 1'b1;
    pulse(0);
    repeat (4) @(posedge mclk_in);
    pulse(1);
    gap(8, "quick_gap");
    poll(2, "quick_ready");
    gap(2, "crystal_gap");
    // Clock-stopped idle with an RC source: quick wake has no effect
    high_osc_kind_in <= 2'h1;
    apb(1, 12'h000, 32'h13);
    pulse(0);
    repeat (4) @(posedge mclk_in);
    check("idle_stop_tick", sys_clk_tick_out, 0);
    apb(0, 12'h000, 32'h0);
    check("idle_stop_flags", v, 32'h1B);
    pulse(1);
    gap(2, "rc_wake_gap");
    // Clock-stopped idle with the crystal: quick wake runs on the slow clock
    high_osc_kind_in <= 2'h0;
    pulse(0);
    repeat (4) @(posedge mclk_in);
    pulse(1);
    gap(8, "idle_quick_gap");
    poll(2, "idle_quick_ready");
    stop_test();
  end
endmodule
